// ==== sgw_pkg.sv ====
package sgw_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_DELIM  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_TXDATA = 8'h10;
    localparam logic [7:0] ADDR_RXDATA = 8'h14;
    localparam logic [7:0] ADDR_ADDR   = 8'h18;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_READY_BIT = 0;
    localparam int CTRL_FAULT_BIT = 1;
    localparam int CTRL_TXGO_BIT  = 2;
    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_START_BIT  = 2;
    localparam int CFG_END2_BIT   = 3;
    localparam int CFG_LEN_BIT    = 4;
    localparam int CFG_TMO_BIT    = 5;
    localparam int CFG_TRIG_BIT   = 6;
    localparam int CFG_MAXLEN_LSB = 8;
    localparam int CFG_DELAY_LSB  = 16;

    // ****************************************
    // Reset values and codes
    // ****************************************
    localparam logic [31:0] CFG_RESET   = 32'h0000_E020;
    localparam logic [31:0] DELIM_RESET = 32'h0000_0000;
    localparam logic [7:0]  TEST_ADDR   = 8'h63;
    localparam logic [3:0]  DIGIT_MAX   = 4'h9;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam int          TXFRAME_DEF = 8;

    typedef enum logic [1:0] {
        MODE_DELIM = 2'b00,
        MODE_CDLY  = 2'b01,
        MODE_COUNT = 2'b10
    } mode_e;

    typedef enum logic [1:0] {
        RX_HUNT  = 2'b00,
        RX_DATA  = 2'b01,
        RX_END2  = 2'b10
    } rx_state_e;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } char_s;

endpackage

// ==== serial_gateway.sv ====
// How it works
// - Start char enabled (delimiter mode only): hunt and align on it
// - Start char disabled: store every next char
// - Delimiter mode: end char or pair closes receive telegram
// - Start and second end chars configurable
// - Length byte set: send that many chars
// - No length byte: delimiter mode sends through end char, other modes send the configured length
// - Never send beyond configured data length
// - Timeout aborts unfinished delimiter telegram
// - Timeout monitoring can be switched off
// - Delay mode: silence closes the telegram
// - Delay time comes from parameter data
// - Delay mode sends data unchanged
// - Count mode: transparent, no timing
// - Count mode sends data unchanged, no ack
// - Count mode forwards replies unchanged
// - Address from tens and ones switches
// - Switch setting 99 is test address
// - Green ready, red fault, fault halts
// - RTS and CTS never gate sending
// - Trigger mode: send on trigger change
// - Length option: store received count
module serial_gateway
    import sgw_pkg::*;
#(
    parameter int BUF_DEPTH = 256,
    parameter int AW        = 8
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    // AXI4-Lite slave
    input  wire logic [AW-1:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [AW-1:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Serial character side (UART outside)
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    input  wire logic        tx_ready,
    input  wire logic        rts_in,
    input  wire logic        cts_in,
    // Rotary switches and status indicator
    input  wire logic [3:0]  sw_tens,
    input  wire logic [3:0]  sw_ones,
    output logic [6:0]       station_addr,
    output logic             test_addr,
    output logic             led_green,
    output logic             led_red,
    // Telegram events
    output logic             rx_done,
    output logic             rx_abort
);

    // ****************************************
    // Helper functions
    // ****************************************
    function automatic logic [7:0] bin_of(input logic [3:0] t, input logic [3:0] o);
        bin_of = ({4'h0, t} << 3) + ({4'h0, t} << 1) + {4'h0, o};
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [31:0] cfg;
    logic [31:0] delim;
    logic        fault;
    logic        ready;
    logic [7:0]  tx_mem [BUF_DEPTH];
    logic [7:0]  rx_mem [BUF_DEPTH];
    logic [7:0]  rx_cnt;
    logic [7:0]  rx_len;
    logic [7:0]  rd_ptr;
    logic        tx_busy;
    logic [7:0]  tx_idx;
    logic [7:0]  tx_lim;
    logic        tx_dirty;
    logic [7:0]  last_trig;
    logic [15:0] gap_cnt;
    rx_state_e   rx_state;
    mode_e       mode;
    logic        tmo_en;
    logic        tx_go;
    char_s       rx_ch;

    assign mode   = mode_e'(cfg[CFG_MODE_LSB +: 2]);
    assign tmo_en = cfg[CFG_TMO_BIT];
    assign rx_ch  = '{valid: rx_valid & clk_en & ready & ~fault, data: rx_data};

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic        aw_hold;
    logic        w_hold;
    logic [AW-1:0] aw_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        wr_fire;
    logic        wr_ok;
    logic [7:0]  rd_word;

    assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
    assign wr_fire = clk_en & aw_hold & w_hold & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_ok = (aw_q[7:0] <= ADDR_ADDR) && (aw_q[1:0] == 2'b00);

    // Address and data captured independently, either order
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            ws_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Config written by the master during start-up
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg <= CFG_RESET;
            delim <= DELIM_RESET;
            ready <= 1'b0;
            tx_go <= 1'b0;
        end else if (clk_en) begin
            tx_go <= 1'b0;
            if (wr_fire) begin
                case (aw_q[7:0])
                    ADDR_CTRL: begin
                        if (ws_q[0]) ready <= w_q[CTRL_READY_BIT];
                        if (ws_q[0]) tx_go <= w_q[CTRL_TXGO_BIT];
                    end
                    ADDR_CFG: begin
                        for (int b = 0; b < 4; b++) begin
                            if (ws_q[b]) cfg[8*b +: 8] <= w_q[8*b +: 8];
                        end
                    end
                    ADDR_DELIM: begin
                        for (int b = 0; b < 4; b++) begin
                            if (ws_q[b]) delim[8*b +: 8] <= w_q[8*b +: 8];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // Transmit buffer words: one byte per write, index from data bits 15:8
    always_ff @(posedge sys_clk) begin
        if (clk_en && wr_fire && aw_q[7:0] == ADDR_TXDATA && ws_q[0]) begin
            tx_mem[w_q[15:8]] <= w_q[7:0];
        end
    end

    // Read port; RXDATA index taken from rd_ptr
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
            rd_ptr <= '0;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                case (s_axi_araddr[7:0])
                    ADDR_CTRL:   s_axi_rdata <= {29'h0, tx_go, fault, ready};
                    ADDR_CFG:    s_axi_rdata <= cfg;
                    ADDR_DELIM:  s_axi_rdata <= delim;
                    ADDR_STATUS: s_axi_rdata <= {16'h0, rx_len, 5'h0, rx_state, tx_busy};
                    ADDR_RXDATA: begin
                        s_axi_rdata <= {16'h0, rd_ptr, rd_word};
                        rd_ptr <= 8'(rd_ptr + 8'h01);
                    end
                    ADDR_ADDR:   s_axi_rdata <= {23'h0, test_addr, 1'b0, station_addr};
                    default: begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (rx_done) rd_ptr <= '0;
        end
    end

    // Length byte option places received count in first slot, data one slot up
    assign rd_word = (cfg[CFG_LEN_BIT] && rd_ptr == 8'h00) ? rx_len
                   : rx_mem[8'(rd_ptr - {7'h0, cfg[CFG_LEN_BIT]})];

    // ****************************************
    // Address switches and indicator
    // ****************************************
    // Digits above 9 are a switch fault, shown red
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            station_addr <= '0;
            test_addr <= 1'b0;
            fault <= 1'b0;
        end else if (clk_en) begin
            station_addr <= 7'(bin_of(sw_tens, sw_ones));
            test_addr <= (bin_of(sw_tens, sw_ones) == TEST_ADDR);
            fault <= (sw_tens > DIGIT_MAX) || (sw_ones > DIGIT_MAX);
        end
    end

    assign led_green = ready & ~fault;
    assign led_red   = fault;

    // ****************************************
    // Receive path
    // ****************************************
    logic [7:0] max_len;
    logic       is_start;
    logic       is_end1;
    logic       is_end2;
    logic       gap_hit;
    logic       gap_live;
    logic       cfg_wr;
    assign max_len  = cfg[CFG_MAXLEN_LSB +: 8];
    assign is_start = rx_ch.data == delim[7:0];
    assign is_end1  = rx_ch.data == delim[15:8];
    assign is_end2  = rx_ch.data == delim[23:16];
    // Timer starts with the telegram, so an idle line never times out
    assign gap_live = rx_state != RX_HUNT && ((mode == MODE_DELIM && cfg[CFG_START_BIT]) || rx_cnt != 8'h00);
    // New framing setup restarts the hunt
    assign cfg_wr   = wr_fire && aw_q[7:0] == ADDR_CFG;
    // Count mode timer never fires; delay mode ignores the enable bit
    assign gap_hit  = (gap_cnt == cfg[CFG_DELAY_LSB +: 16]) && gap_live &&
                      (mode == MODE_CDLY || (mode == MODE_DELIM && tmo_en));

    always_ff @(posedge sys_clk) begin
        if (rx_ch.valid && rx_state != RX_HUNT && rx_cnt < max_len) begin
            rx_mem[rx_cnt] <= rx_ch.data;
        end
    end

    // Framing state machine; stored count is the telegram length
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rx_state <= RX_HUNT;
            rx_cnt <= '0;
            rx_len <= '0;
            gap_cnt <= '0;
            rx_done <= 1'b0;
            rx_abort <= 1'b0;
        end else if (clk_en) begin
            rx_done <= 1'b0;
            rx_abort <= 1'b0;
            if (rx_ch.valid || !gap_live) gap_cnt <= '0;
            else if (gap_cnt != 16'hFFFF) gap_cnt <= 16'(gap_cnt + 16'h0001);
            if (fault || !ready || cfg_wr) begin
                rx_state <= RX_HUNT;
                rx_cnt <= '0;
            end else if (gap_hit) begin
                rx_state <= RX_HUNT;
                rx_cnt <= '0;
                if (mode == MODE_CDLY) begin
                    rx_done <= 1'b1;
                    rx_len <= rx_cnt;
                end else begin
                    rx_abort <= 1'b1;
                end
            end else begin
                case (rx_state)
                    RX_HUNT: begin
                        if (mode != MODE_DELIM || !cfg[CFG_START_BIT]) begin
                            rx_state <= RX_DATA;
                        end else if (rx_ch.valid && is_start) begin
                            rx_state <= RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_ch.valid) begin
                            if (rx_cnt < max_len) rx_cnt <= 8'(rx_cnt + 8'h01);
                            if (mode == MODE_DELIM && is_end1) begin
                                if (cfg[CFG_END2_BIT]) begin
                                    rx_state <= RX_END2;
                                end else begin
                                    rx_state <= RX_HUNT;
                                    rx_done <= 1'b1;
                                    rx_len <= 8'(rx_cnt + 8'h01);
                                    rx_cnt <= '0;
                                end
                            end else if (mode == MODE_COUNT) begin
                                rx_done <= 1'b1;
                                rx_len <= 8'(rx_cnt + 8'h01);
                            end
                        end
                    end
                    RX_END2: begin
                        if (rx_ch.valid) begin
                            if (rx_cnt < max_len) rx_cnt <= 8'(rx_cnt + 8'h01);
                            rx_state <= is_end2 ? RX_HUNT : RX_DATA;
                            if (is_end2) begin
                                rx_done <= 1'b1;
                                rx_len <= 8'(rx_cnt + 8'h01);
                                rx_cnt <= '0;
                            end
                        end
                    end
                    default: rx_state <= RX_HUNT;
                endcase
            end
        end
    end

    // ****************************************
    // Transmit path
    // ****************************************
    logic [7:0] len_byte;
    logic [7:0] data_base;
    logic [7:0] want;
    logic       tx_end_hit;
    logic       trig_on;
    assign trig_on   = cfg[CFG_TRIG_BIT];
    assign data_base = 8'({trig_on, 1'b0} >> 1) + 8'(cfg[CFG_LEN_BIT]);
    assign len_byte  = tx_mem[8'(trig_on)];
    // Length byte is clipped to the configured length
    assign want = (cfg[CFG_LEN_BIT] && len_byte < max_len) ? len_byte : max_len;
    assign tx_end_hit = mode == MODE_DELIM && !cfg[CFG_LEN_BIT] && tx_data == delim[15:8];

    // Change detect: any CTRL write with TXGO set marks data dirty unless trigger mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_dirty <= 1'b0;
            last_trig <= '0;
        end else if (clk_en) begin
            if (tx_go) begin
                if (!trig_on) tx_dirty <= 1'b1;
                else if (tx_mem[0] != last_trig) tx_dirty <= 1'b1;
                last_trig <= tx_mem[0];
            end else if (fault || (!tx_busy && tx_dirty && ready)) begin
                tx_dirty <= 1'b0;
            end
        end
    end

    // Sender: plain bytes, no framing added; handshake pins ignored
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            tx_busy <= 1'b0;
            tx_idx <= '0;
            tx_lim <= '0;
            tx_valid <= 1'b0;
            tx_data <= '0;
        end else if (clk_en) begin
            if (!tx_busy) begin
                if (tx_dirty && ready && !fault && want != 8'h00) begin
                    tx_busy <= 1'b1;
                    tx_idx <= 8'h01;
                    tx_lim <= want;
                    tx_valid <= 1'b1;
                    tx_data <= tx_mem[data_base];
                end
            end else if (tx_valid && tx_ready) begin
                if (tx_idx >= tx_lim || tx_end_hit || fault) begin
                    tx_busy <= 1'b0;
                    tx_valid <= 1'b0;
                end else begin
                    tx_idx <= 8'(tx_idx + 8'h01);
                    tx_data <= tx_mem[8'(data_base + tx_idx)];
                end
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_tx_bound: assert property (@(posedge sys_clk) disable iff (!nrst)
        tx_busy |-> tx_idx <= max_len)
        else $error("transmit ran past configured length");
    chk_end_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && tx_valid && tx_ready && tx_end_hit) |=> !tx_busy)
        else $error("sender did not stop after end char");
    chk_fault_halt: assert property (@(posedge sys_clk) disable iff (!nrst)
        (fault && !tx_busy) |=> !tx_busy)
        else $error("transmit started during fault");
    chk_tmo_off: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == MODE_DELIM && !tmo_en) |=> !rx_abort)
        else $error("abort with timeout disabled");
    chk_count_notmo: assert property (@(posedge sys_clk) disable iff (!nrst)
        (mode == MODE_COUNT) |=> !rx_abort)
        else $error("timer active in count mode");
    chk_hunt_start: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && rx_state == RX_HUNT && mode == MODE_DELIM && cfg[CFG_START_BIT] && !gap_hit
         && ready && !fault && !(rx_ch.valid && is_start)) |=> rx_state == RX_HUNT)
        else $error("left hunt without start char");
    chk_test_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clk_en && sw_tens == 4'h9 && sw_ones == 4'h9) |=> test_addr)
        else $error("address 99 not flagged as test");
    chk_led_excl: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(led_green && led_red))
        else $error("indicator green and red together");

endmodule

// ==== serial_dev_model.sv ====
module serial_dev_model (
    // Clock and pacing
    input  wire logic       sys_clk,
    input  wire logic       slow,
    // Gateway transmit side
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready,
    // Gateway receive side
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] got[$];
    logic       phase;

    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        phase    = 1'b0;
    end

    // Slow mode takes every other cycle, so the sender must hold its char
    always @(posedge sys_clk) begin
        phase    <= ~phase;
        tx_ready <= ~slow | phase;
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
    end

    // One char pulse; the bus then shows the inverse so a stale byte never matches
    task automatic send(input logic [7:0] b, input int gap);
        @(posedge sys_clk);
        rx_valid <= 1'b1;
        rx_data  <= b;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_data  <= ~b;
        repeat (gap) @(posedge sys_clk);
    endtask
endmodule

// ==== serial_gateway_framing_modes_tb_top.sv ====
module serial_gateway_framing_modes_tb_top import sgw_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, nrst, clk_en, slow, rts_in, cts_in, tx_valid, tx_ready, rx_valid;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, rx_data, tx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb, sw_tens, sw_ones;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [6:0]  station_addr;
    logic        test_addr, led_green, led_red, rx_done, rx_abort;
    int          errors, checks, ndone, nabort, d0, a0;

    serial_gateway DUT (
        .sys_clk, .nrst, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_ready, .rts_in, .cts_in, .sw_tens, .sw_ones,
        .station_addr, .test_addr, .led_green, .led_red, .rx_done, .rx_abort
    );
    serial_dev_model model (.sys_clk, .slow, .tx_valid, .tx_data, .tx_ready, .rx_valid, .rx_data);

    // ****************************************
    // Clock, event counters, tasks
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Telegram events are one-cycle pulses, so tally them every edge
    always @(posedge sys_clk) begin
        if (rx_done === 1'b1) ndone++;
        if (rx_abort === 1'b1) nabort++;
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        stop_test();
    end

    task automatic stop_test;
        if (errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Address and data offered together, each released once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd   = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    function automatic logic [31:0] mk(input logic [1:0] m, input logic [4:0] f, input logic [7:0] ml,
                                       input logic [15:0] dl);
        return {dl, ml, 1'b0, f, m};
    endfunction

    // Posts the buffer and compares every char the far device saw
    task automatic tx_case(input string nm, input logic [31:0] cfg, input int n, input logic [31:0] e);
        axw(ADDR_CFG, cfg);
        model.got.delete();
        axw(ADDR_CTRL, 32'h0000_0005);
        repeat (4) @(posedge sys_clk);
        for (int k = 0; k < 100; k++) begin
            axr(ADDR_STATUS);
            if (rd[0] === 1'b0) break;
        end
        chk(nm, model.got.size(), n);
        for (int i = 0; i < n; i++) begin
            chk(nm, 32'(model.got[i]), 32'(e[8*i +: 8]));
        end
    endtask

    task automatic rx_send(input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            model.send(b[8*i +: 8], 3);
        end
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {errors, checks, ndone, nabort} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {nrst, rts_in, cts_in} = '0;
        {clk_en, slow} = 2'h3;
        s_axi_wstrb = 4'hF;
        sw_tens = 4'h4;
        sw_ones = 4'h2;
        repeat (2) @(posedge sys_clk);
        nrst <= 1'b1;
        axr(ADDR_CFG);
        chk("cfg_reset", rd, CFG_RESET);
        axr(8'h40);
        chk("rd_unmapped", 32'(resp), 32'(RESP_SLVERR));
        axw(8'h44, 32'h0000_0001);
        chk("wr_unmapped", 32'(resp), 32'(RESP_SLVERR));
        chk("addr_42", 32'(station_addr), 32'h0000_002A);
        chk("leds_off", 32'({led_green, led_red}), 32'h0000_0000);
        axw(ADDR_CTRL, 32'h0000_0001);
        repeat (2) @(posedge sys_clk);
        chk("green", 32'({led_green, led_red}), 32'h0000_0002);
        sw_tens <= 4'h9;
        sw_ones <= 4'h9;
        repeat (3) @(posedge sys_clk);
        chk("addr_99", 32'({test_addr, station_addr}), 32'h0000_00E3);
        axr(ADDR_ADDR);
        chk("addr_reg", rd, 32'h0000_0163);
        // Caller places its own delimiters in the buffer; CTS stays low
        axw(ADDR_DELIM, 32'h000A_0302);
        for (int i = 0; i < 5; i++) axw(ADDR_TXDATA, {16'h0000, i[7:0], 8'(40'h55_0342_4102 >> (8*i))});
        tx_case("delim_end", mk(MODE_DELIM, 5'h00, 8'h08, 16'h0000), 4, 32'h0342_4102);
        slow <= 1'b0;
        axw(ADDR_TXDATA, 32'h0000_0344);
        tx_case("max_len", mk(MODE_DELIM, 5'h00, 8'h03, 16'h0000), 3, 32'h0042_4102);
        tx_case("len_byte", mk(MODE_DELIM, 5'h04, 8'h08, 16'h0000), 2, 32'h0000_4241);
        tx_case("cdly_tx", mk(MODE_CDLY, 5'h08, 8'h04, 16'h0010), 4, 32'h4442_4102);
        tx_case("count_tx", mk(MODE_COUNT, 5'h00, 8'h02, 16'h0000), 2, 32'h0000_4102);
        axw(ADDR_TXDATA, 32'h0000_0007);
        tx_case("trig_new", mk(MODE_COUNT, 5'h10, 8'h02, 16'h0000), 2, 32'h0000_4241);
        tx_case("trig_same", mk(MODE_COUNT, 5'h10, 8'h02, 16'h0000), 0, 32'h0000_0000);
        sw_tens <= 4'hA;
        repeat (3) @(posedge sys_clk);
        chk("red", 32'({led_green, led_red}), 32'h0000_0001);
        tx_case("fault_halt", mk(MODE_COUNT, 5'h00, 8'h02, 16'h0000), 0, 32'h0000_0000);
        sw_tens <= 4'h4;
        // Receive: leading junk dropped until the start char
        axw(ADDR_CFG, mk(MODE_DELIM, 5'h05, 8'hE0, 16'h0000));
        d0 = ndone;
        rx_send(32'h0341_0211, 4);
        chk("rx_start", ndone, d0 + 1);
        axr(ADDR_STATUS);
        chk("rx_len", 32'(rd[15:8]), 32'h0000_0002);
        axr(ADDR_RXDATA);
        chk("len_byte_rx", 32'(rd[7:0]), 32'h0000_0002);
        axw(ADDR_CFG, mk(MODE_DELIM, 5'h02, 8'hE0, 16'h0000));
        d0 = ndone;
        rx_send(32'h0000_0341, 2);
        chk("end_pair_wait", ndone, d0);
        rx_send(32'h0000_000A, 1);
        chk("end_pair_done", ndone, d0 + 1);
        axr(ADDR_RXDATA);
        chk("no_start", 32'(rd[7:0]), 32'h0000_0041);
        // Silence of 16 cycles against a half-finished telegram
        axw(ADDR_CFG, mk(MODE_DELIM, 5'h08, 8'hE0, 16'h0010));
        {d0, a0} = {ndone, nabort};
        rx_send(32'h0000_0041, 1);
        repeat (30) @(posedge sys_clk);
        chk("tmo_abort", nabort, a0 + 1);
        chk("tmo_nodone", ndone, d0);
        axw(ADDR_CFG, mk(MODE_DELIM, 5'h00, 8'hE0, 16'h0010));
        a0 = nabort;
        rx_send(32'h0000_0041, 1);
        repeat (30) @(posedge sys_clk);
        chk("tmo_off", nabort, a0);
        rx_send(32'h0000_0003, 1);
        chk("tmo_off_end", ndone, d0 + 1);
        axw(ADDR_CFG, mk(MODE_CDLY, 5'h08, 8'hE0, 16'h0010));
        d0 = ndone;
        rx_send(32'h0043_4241, 3);
        repeat (8) @(posedge sys_clk);
        chk("cdly_open", ndone, d0);
        repeat (20) @(posedge sys_clk);
        chk("cdly_close", ndone, d0 + 1);
        axw(ADDR_CFG, mk(MODE_COUNT, 5'h08, 8'hE0, 16'h0010));
        {d0, a0} = {ndone, nabort};
        rx_send(32'h0000_005A, 1);
        chk("count_rx", ndone, d0 + 1);
        repeat (30) @(posedge sys_clk);
        chk("count_notime", nabort, a0);
        axr(ADDR_RXDATA);
        chk("count_data", 32'(rd[7:0]), 32'h0000_005A);
        stop_test();
    end
endmodule
